// ---- rtl/fpp_pkg.sv ----
// Package: map, field layout, cycle counts and protection decode for the flash sequencer
package fpp_pkg;

	// ****************************************
	// Address map (byte addresses on the bus)
	// ****************************************
	localparam logic [15:0] ARRAY_BASE = 16'h8000;
	localparam logic [15:0] PROT_START_ADDR = 16'hff80;
	localparam logic [15:0] CTRL_ADDR = 16'hff88;
	localparam logic [15:0] STAT_ADDR = 16'hff8c;

	// ****************************************
	// Field positions and values
	// ****************************************
	localparam int CTL_PGM = 0;
	localparam int CTL_ERASE = 1;
	localparam int CTL_MASS = 2;
	localparam int CTL_HIGH_VOLTAGE_ENABLE = 3;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] PS_RESET = 8'hff;
	localparam logic [7:0] PS_OPEN = 8'hff;
	localparam int ROW_LSB = 6;
	localparam int PAGE_LSB = 7;
	localparam logic [8:0] TOP_PAGE = 9'h1ff;

	// ****************************************
	// Sequence delays in bus-clock cycles
	// ****************************************
	localparam int CNT_W = 20;
	localparam int SETUP_CYC_DEF = 1250;
	localparam int ERASE_CYC_DEF = 12500;
	localparam int MERASE_CYC_DEF = 50000;
	localparam int HOLD_CYC_DEF = 625;
	localparam int RCV_CYC_DEF = 125;

	typedef enum logic [2:0] {
		FPP_IDLE = 3'b000,
		FPP_SELECT = 3'b001,
		FPP_PROT_RD = 3'b011,
		FPP_SETUP = 3'b010,
		FPP_ARMED = 3'b110,
		FPP_ACTIVE = 3'b111,
		FPP_HOLD = 3'b101,
		FPP_RECOVER = 3'b100
	} fpp_state_t;

	// Start address is 1 in bit 15, the byte in 14..7, zeros below
	function automatic logic fpp_prot_hit(input logic [7:0] ps, input logic [15:0] addr);
		logic [15:0] start;
		start = {1'b1, ps, 7'h00};
		fpp_prot_hit = (ps != PS_OPEN) && (addr >= start);
	endfunction

endpackage

// ---- rtl/fpp_flash_ctrl.sv ----
// Flash program/erase sequencer with block protection, APB register slave
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
// ****************************************
// Notes on behaviour
// ****************************************
// Notes on behaviour
// - Erased bits read 1, programmed bits read 0.
// - Pages are two 64-byte rows; erase works on 128-byte pages at least.
// - Programming covers one 64-byte row per operation.
// - High voltage settable only with program or erase selected and sequence kept.
// - Mass select 1 erases the whole array, 0 erases one page.
// - Erase and program select never both 1, never set together.
// - Protect byte lives in flash; changes only by programming or erasing, not bus writes.
// - Start address is 1, protect byte in bits 14..7, zeros below.
// - Everything from start address to the top of memory is protected.
// - All ones protects nothing; all zeros protects the whole array.
// - Each decrement of the protect byte adds one 128-byte page.
// - Value one below all ones protects the top two pages.
// - High voltage refused for erase or program of a protected region; mass erase checks only the latched address against the protect byte.
// - Host reads protect byte after selecting mode, before high voltage.
// - Erasing an unprotected top page also erases the protect byte.
// - Clearing high voltage removes it and stops the pump.
// - Low-power mode suspends operations and puts the array in standby.
module fpp_flash_ctrl import fpp_pkg::*; #(
	parameter int SETUP_CYC = SETUP_CYC_DEF,
	parameter int ERASE_CYC = ERASE_CYC_DEF,
	parameter int MERASE_CYC = MERASE_CYC_DEF,
	parameter int HOLD_CYC = HOLD_CYC_DEF,
	parameter int RCV_CYC = RCV_CYC_DEF
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [15:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic low_power,
	input wire logic [7:0] arr_rdata,
	output logic arr_hv,
	output logic arr_erase,
	output logic arr_mass,
	output logic arr_prog,
	output logic arr_wstb,
	output logic [15:0] arr_addr,
	output logic [7:0] arr_wdata
);

	// ****************************************
	// Bus decode
	// ****************************************
	logic acc, wr, rd, mapped, is_ctl, is_stat, is_ps, arr_wr;
	logic prog, erase, mass, high_voltage_enable, refused, row_fault;
	logic [7:0] ps;
	logic [15:0] latch;
	logic [CNT_W-1:0] cnt;
	fpp_state_t st;
	logic hv_req, hv_ok, mode_sel, ps_read, erase_start;

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign mapped = paddr >= ARRAY_BASE;
	assign is_ctl = paddr == CTRL_ADDR;
	assign is_stat = paddr == STAT_ADDR;
	assign is_ps = paddr == PROT_START_ADDR;
	// The protect byte location counts as array space for writes
	assign arr_wr = wr & mapped & ~is_ctl & ~is_stat;
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	assign ps_read = rd & is_ps;
	assign mode_sel = erase | prog;
	assign hv_req = wr & is_ctl & pwdata[CTL_HIGH_VOLTAGE_ENABLE] & ~high_voltage_enable;
	// Gate on sequence position, mode and protection of the latched address
	assign hv_ok = (st == FPP_ARMED) & mode_sel & ~low_power
		& ~fpp_prot_hit(ps, latch);
	assign erase_start = hv_req & hv_ok & erase;

	// ****************************************
	// Read data, captured in the setup phase
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			if (!mapped) begin
				prdata <= 32'h0000_0000;
			end else if (is_ctl) begin
				prdata <= {28'h000_0000, high_voltage_enable, mass, erase, prog};
			end else if (is_stat) begin
				prdata <= {25'h000_0000, st, low_power, row_fault, refused, (cnt == '0)};
			end else if (is_ps) begin
				prdata <= {24'h00_0000, ps};
			end else begin
				prdata <= {24'h00_0000, arr_rdata};
			end
		end
	end

	// ****************************************
	// Control bits
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			prog <= 1'b0;
			erase <= 1'b0;
			mass <= 1'b0;
			high_voltage_enable <= 1'b0;
		end else if (wr & is_ctl) begin
			// A write asking for both selects sets neither
			prog <= pwdata[CTL_PGM] & ~pwdata[CTL_ERASE] & ~erase;
			erase <= pwdata[CTL_ERASE] & ~pwdata[CTL_PGM] & ~prog;
			mass <= pwdata[CTL_MASS];
			// Clearing always wins; setting needs the gate
			high_voltage_enable <= pwdata[CTL_HIGH_VOLTAGE_ENABLE] & (high_voltage_enable | hv_ok);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			refused <= 1'b0;
		end else if (hv_req & ~hv_ok) begin
			refused <= 1'b1;
		end else if (wr & is_ctl) begin
			refused <= 1'b0;
		end
	end

	// ****************************************
	// Sequence and delay counter
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			st <= FPP_IDLE;
			cnt <= '0;
		end else if (!low_power) begin
			// Low power freezes the sequence where it stands
			if (cnt != '0) begin
				cnt <= cnt - 1'b1;
			end
			case (st)
				FPP_IDLE: begin
					if (mode_sel) begin
						st <= FPP_SELECT;
					end
				end
				FPP_SELECT: begin
					if (!mode_sel) begin
						st <= FPP_IDLE;
					end else if (ps_read) begin
						st <= FPP_PROT_RD;
					end
				end
				FPP_PROT_RD: begin
					if (!mode_sel) begin
						st <= FPP_IDLE;
					end else if (arr_wr) begin
						st <= FPP_SETUP;
						cnt <= CNT_W'(SETUP_CYC);
					end
				end
				FPP_SETUP: begin
					if (!mode_sel) begin
						st <= FPP_IDLE;
					end else if (cnt == '0) begin
						st <= FPP_ARMED;
					end
				end
				FPP_ARMED: begin
					if (!mode_sel) begin
						st <= FPP_IDLE;
					end else if (hv_req & hv_ok) begin
						st <= FPP_ACTIVE;
						cnt <= CNT_W'(mass ? MERASE_CYC : ERASE_CYC);
					end
				end
				FPP_ACTIVE: begin
					if (wr & is_ctl & ~pwdata[CTL_HIGH_VOLTAGE_ENABLE]) begin
						st <= FPP_RECOVER;
						cnt <= CNT_W'(RCV_CYC);
					end else if (!mode_sel) begin
						st <= FPP_HOLD;
						cnt <= CNT_W'(HOLD_CYC);
					end
				end
				FPP_HOLD: begin
					if (!high_voltage_enable) begin
						st <= FPP_RECOVER;
						cnt <= CNT_W'(RCV_CYC);
					end
				end
				FPP_RECOVER: begin
					if (cnt == '0) begin
						st <= FPP_IDLE;
					end
				end
				default: begin
					st <= FPP_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Latched address, program strobes, row check
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			latch <= 16'h0000;
		end else if (st == FPP_PROT_RD && arr_wr && !low_power) begin
			latch <= paddr;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			arr_wstb <= 1'b0;
			arr_addr <= 16'h0000;
			arr_wdata <= 8'h00;
			row_fault <= 1'b0;
		end else begin
			arr_wstb <= 1'b0;
			if (st == FPP_ACTIVE && prog && high_voltage_enable && arr_wr && !low_power) begin
				// Only bytes in the latched row are passed on
				if (paddr[15:ROW_LSB] == latch[15:ROW_LSB]) begin
					arr_wstb <= 1'b1;
					arr_addr <= paddr;
					arr_wdata <= pwdata[7:0];
				end else begin
					row_fault <= 1'b1;
				end
			end else if (st == FPP_IDLE && mode_sel) begin
				row_fault <= 1'b0;
			end
		end
	end

	// ****************************************
	// Protect byte, held as an array cell
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			ps <= PS_RESET;
		end else if (erase_start && !fpp_prot_hit(ps, PROT_START_ADDR)
				&& (mass || latch[15:PAGE_LSB] == TOP_PAGE)) begin
			// No hardware shields it; the vector page erase takes it along
			ps <= ERASED_BYTE;
		end else if (st == FPP_ACTIVE && prog && high_voltage_enable && arr_wr && is_ps
				&& latch[15:ROW_LSB] == PROT_START_ADDR[15:ROW_LSB] && !low_power) begin
			// Programming can only clear bits
			ps <= ps & pwdata[7:0];
		end
	end

	// ****************************************
	// Array controls
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			arr_hv <= 1'b0;
			arr_erase <= 1'b0;
			arr_mass <= 1'b0;
			arr_prog <= 1'b0;
		end else begin
			// Standby: every control to the array inactive
			arr_hv <= high_voltage_enable & ~low_power;
			arr_erase <= erase & ~low_power;
			arr_mass <= mass & erase & ~low_power;
			arr_prog <= prog & ~low_power;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	AST_INTERLOCK: assert property (@(posedge core_clk) disable iff (!rstn)
		!(erase && prog)) else $error("erase and program both set");

	AST_HV_NEEDS_MODE: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(high_voltage_enable) |-> $past(erase || prog) && $past(st) == FPP_ARMED)
		else $error("high voltage set without selected mode");

	AST_HV_PROTECTED: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(high_voltage_enable) |-> !fpp_prot_hit(ps, latch)) else $error("high voltage on protected area");

	AST_HV_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
		!high_voltage_enable |=> !arr_hv) else $error("high voltage stays after clear");

	AST_STANDBY: assert property (@(posedge core_clk) disable iff (!rstn)
		low_power |=> !arr_hv && !arr_erase && !arr_prog && !arr_wstb)
		else $error("array active in low power");

	AST_PS_NO_BUSWRITE: assert property (@(posedge core_clk) disable iff (!rstn)
		(ps != $past(ps)) |-> $past(high_voltage_enable) || $rose(high_voltage_enable)) else $error("protect byte changed outside op");

	AST_ALL_ZERO: assert property (@(posedge core_clk) disable iff (!rstn)
		(ps == 8'h00 && hv_req) |=> !high_voltage_enable) else $error("all-zero protect allowed high voltage");

	AST_ROW: assert property (@(posedge core_clk) disable iff (!rstn)
		arr_wstb |-> arr_addr[15:ROW_LSB] == latch[15:ROW_LSB]) else $error("strobe outside row");

	AST_SEQ_ORDER: assert property (@(posedge core_clk) disable iff (!rstn)
		(st == FPP_SETUP && $past(st) != FPP_SETUP) |-> $past(st) == FPP_PROT_RD)
		else $error("setup entered without protect read");

	AST_TOP_TWO: assert property (@(posedge core_clk) disable iff (!rstn)
		(ps == 8'hfe && hv_req && latch[15:8] != 8'hff && st == FPP_ARMED && mode_sel
		&& !low_power) |=> high_voltage_enable) else $error("fe protects too much");

	AST_ROW_REFUSE: assert property (@(posedge core_clk) disable iff (!rstn)
		(st == FPP_ACTIVE && prog && high_voltage_enable && arr_wr && !low_power
		&& paddr[15:ROW_LSB] != latch[15:ROW_LSB]) |=> !arr_wstb && row_fault) else $error("row");

	AST_PS_ERASED: assert property (@(posedge core_clk) disable iff (!rstn)
		(erase_start && mass && !fpp_prot_hit(ps, PROT_START_ADDR)) |=> ps == ERASED_BYTE)
		else $error("protect byte kept over erase");

	AST_MODE_TO_ARRAY: assert property (@(posedge core_clk) disable iff (!rstn)
		!low_power |=> arr_erase == $past(erase) && arr_mass == $past(mass && erase)
		&& arr_prog == $past(prog)) else $error("array mode differs from control");

	AST_OPEN_ALLOWS: assert property (@(posedge core_clk) disable iff (!rstn)
		(st == FPP_ARMED && hv_req && mode_sel && !low_power && ps == PS_OPEN) |=> high_voltage_enable)
		else $error("open array refused high voltage");

	AST_PAGE_STEP: assert property (@(posedge core_clk) disable iff (!rstn)
		(st == FPP_ARMED && hv_req && mode_sel && !low_power
		&& latch[15:PAGE_LSB] < {1'b1, ps}) |=> high_voltage_enable) else $error("page below start refused");

	AST_PS_PROG_AND: assert property (@(posedge core_clk) disable iff (!rstn)
		(st == FPP_ACTIVE && prog && high_voltage_enable && arr_wr && is_ps && !low_power
		&& latch[15:ROW_LSB] == PROT_START_ADDR[15:ROW_LSB])
		|=> ps == ($past(ps) & $past(pwdata[7:0]))) else $error("protect byte program wrong");

	AST_MASS_PROTECTED: assert property (@(posedge core_clk) disable iff (!rstn)
		(st == FPP_ARMED && hv_req && erase && mass && fpp_prot_hit(ps, latch))
		|=> !high_voltage_enable && refused) else $error("mass erase on protected address");

	AST_HV_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn)
		(wr && is_ctl && !pwdata[CTL_HIGH_VOLTAGE_ENABLE]) |=> !high_voltage_enable) else $error("high voltage not cleared");

endmodule

// ---- sim/fpp_array_model.sv ----
// Flash array model: erased bytes read as ones, programming only clears bits
`timescale 1ns/1ps
module fpp_array_model (
	input wire logic core_clk,
	input wire logic [15:0] paddr,
	input wire logic arr_hv,
	input wire logic arr_erase,
	input wire logic arr_wstb,
	input wire logic [15:0] arr_addr,
	input wire logic [7:0] arr_wdata,
	output logic [7:0] arr_rdata
);
	// Only 256 bytes kept; upper address bits alias to save memory
	logic [7:0] mem [256];
	initial foreach (mem[i]) mem[i] = 8'hff;
	always @(posedge core_clk) begin
		if (arr_hv && arr_erase) begin
			foreach (mem[i]) mem[i] <= 8'hff;
		end else if (arr_wstb) begin
			mem[arr_addr[7:0]] <= mem[arr_addr[7:0]] & arr_wdata;
		end
	end
	assign arr_rdata = mem[paddr[7:0]];
endmodule

// ---- sim/flash_program_erase_protect_test.sv ----
// Self-checking bench: sequences, interlock and block protection of the sequencer
`timescale 1ns/1ps
module flash_program_erase_protect_test import fpp_pkg::*;;
	logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, low_power = 0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, arr_hv, arr_erase, arr_mass, arr_prog, arr_wstb;
	logic [15:0] arr_addr, wst_a, a;
	logic [7:0] arr_wdata, arr_rdata, wst_d, v;
	int error_cnt = 0, cmp_count = 0, wst_n = 0, n0;

	always #4 core_clk = ~core_clk;

	fpp_flash_ctrl #(.SETUP_CYC(4), .ERASE_CYC(4), .MERASE_CYC(4), .HOLD_CYC(4), .RCV_CYC(4))
		i_fpp_flash_ctrl (.core_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .low_power, .arr_rdata, .arr_hv, .arr_erase, .arr_mass,
		.arr_prog, .arr_wstb, .arr_addr, .arr_wdata);
	fpp_array_model i_fpp_array_model (.core_clk, .paddr, .arr_hv, .arr_erase, .arr_wstb,
		.arr_addr, .arr_wdata, .arr_rdata);

	always @(posedge core_clk) if (arr_wstb) begin
		wst_n <= wst_n + 1;
		wst_a <= arr_addr;
		wst_d <= arr_wdata;
	end

	// ****************************************
	// Checks and bus tasks
	// ****************************************
	task automatic tally_and_finish;
		if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [15:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wait_state(input logic [2:0] s);
		for (int k = 0; k < 40; k++) begin
			apb(0, STAT_ADDR, 32'h0);
			if (rd[6:4] === s) break;
		end
		chk_word({29'h0, rd[6:4]}, {29'h0, s});
	endtask
	task automatic finish_seq;
		apb(1, CTRL_ADDR, 32'h8);
		apb(1, CTRL_ADDR, 32'h0);
		wait_state(3'b000);
		chk_bit(arr_hv, 0);
	endtask
	// Protected when the byte is not all ones and the address is at or above the start
	function automatic logic prot(input logic [7:0] ps, input logic [15:0] ad);
		return ps != 8'hff && ad >= {1'b1, ps, 7'h00};
	endfunction
	// Register addresses are no array targets, so move to the vector half of the page
	function automatic logic [15:0] fix(input logic [15:0] ad);
		return (ad[15:4] == 12'hff8) ? (ad | 16'h0040) : ad;
	endfunction
	// One sequence at a time, no interrupts, array left alone meanwhile
	task automatic try_erase(input logic [7:0] ps, input logic [15:0] ad, input logic mass);
		logic p;
		p = prot(ps, ad);
		apb(1, CTRL_ADDR, {29'h0, mass, 2'b10});
		apb(0, PROT_START_ADDR, 32'h0);
		chk_word(rd, {24'h0, ps});
		apb(1, ad, $urandom);
		wait_state(3'b110);
		apb(1, CTRL_ADDR, {28'h0, 1'b1, mass, 2'b10});
		repeat (2) @(posedge core_clk);
		chk_bit(arr_hv, !p);
		chk_bit(arr_mass, mass);
		chk_bit(arr_erase, 1);
		apb(0, STAT_ADDR, 32'h0);
		chk_bit(rd[1], p);
		finish_seq;
		apb(0, ad, 32'h0);
		if (!p) chk_word(rd, 32'hff);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		void'($urandom(32'h8c5f4ab2));
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 8'hfe : (i == 1) ? 8'h00 : (i == 2) ? 8'hff : 8'($urandom);
			rstn <= 0;
			repeat (20) @(posedge core_clk);
			rstn <= 1;
			apb(0, CTRL_ADDR, 32'h0);
			chk_word(rd, 32'h0);
			apb(0, 16'h7ffc, 32'h0);
			chk_bit(err, 1);
			apb(1, CTRL_ADDR, 32'h3);
			apb(0, CTRL_ADDR, 32'h0);
			chk_bit(rd[0] & rd[1], 0);
			apb(1, CTRL_ADDR, 32'h0);
			apb(1, CTRL_ADDR, 32'h2);
			apb(1, CTRL_ADDR, 32'h3);
			apb(0, CTRL_ADDR, 32'h0);
			chk_word(rd, 32'h0);
			apb(1, CTRL_ADDR, 32'h0);
			wait_state(3'b000);
			apb(1, PROT_START_ADDR, {24'h0, v});
			apb(0, PROT_START_ADDR, 32'h0);
			chk_word(rd, 32'hff);
			apb(1, CTRL_ADDR, 32'h1);
			apb(0, PROT_START_ADDR, 32'h0);
			apb(1, PROT_START_ADDR, 32'h0);
			wait_state(3'b110);
			apb(1, CTRL_ADDR, 32'h9);
			repeat (2) @(posedge core_clk);
			chk_bit(arr_hv & arr_prog, 1);
			low_power <= 1;
			repeat (2) @(posedge core_clk);
			chk_bit(arr_hv, 0);
			low_power <= 0;
			repeat (2) @(posedge core_clk);
			chk_bit(arr_hv, 1);
			n0 = wst_n;
			apb(1, PROT_START_ADDR, {24'h0, v});
			repeat (2) @(posedge core_clk);
			chk_word({wst_d, wst_a, 8'(wst_n - n0)}, {v, PROT_START_ADDR, 8'h1});
			apb(1, 16'hffc0, 32'h0);
			apb(0, STAT_ADDR, 32'h0);
			chk_bit(rd[2], 1);
			chk_word(32'(wst_n - n0), 32'h1);
			finish_seq;
			a = {1'b1, v, 7'h00};
			try_erase(v, (v == 8'h0) ? 16'hffff : fix(a), 0);
			try_erase(v, (v == 8'h0) ? 16'h8000 : a - 16'h1, 1);
			try_erase(v, fix({1'b1, 15'($urandom)}), 1'(i));
		end
		tally_and_finish;
	end

	initial begin
		repeat (40000) @(posedge core_clk);
		error_cnt++;
		tally_and_finish;
	end
endmodule
